// ### acis_irq.sv
// interrupt flag servicing: motion flags in three servicing modes, sample flag in latched and auto, queue flags in latched only
`include "acis_regs.svh"

module acis_irq #(
  parameter int TEMP_LATCH_CYCLES = `ACIS_TEMP_LATCH_CYC,
  parameter int QUEUE_DEPTH = `ACIS_QUEUE_DEPTH
) (
  input wire logic CLK,
  input wire logic RST,
  input wire acis_pkg::acis_host_t HOST,
  input wire acis_pkg::acis_en_t INT_EN,
  input wire acis_pkg::acis_mode_t MODE,
  input wire logic PER_BIT_CLEAR_SELECT,
  input wire logic Z_DONE,
  input wire logic Z_ACCUM_START,
  input wire logic TF_EVAL,
  input wire acis_pkg::acis_tf_t TF_STATE,
  input wire logic ANYM_EVT,
  input wire logic SHAKE_EVT,
  input wire logic TILT35_EVT,
  input wire logic [4:0] MOTION_COND,
  input wire logic WAKE,
  input wire logic QUEUE_EN,
  input wire logic SAMPLE_WR,
  input wire logic [5:0] QUEUE_THRESH,
  output logic [7:0] INT_STATUS,
  output logic [2:0] QUEUE_STATUS,
  output logic [2:0] QUEUE_LEVEL,
  output logic [5:0] QUEUE_COUNT,
  output logic INT1_REQ,
  output logic INT2_REQ
);

  localparam int TW = $clog2(TEMP_LATCH_CYCLES + 1);

  function automatic logic hit(input acis_pkg::acis_host_t h, input logic [7:0] a);
    hit = h.addr == a;
  endfunction : hit

  // ----------------------------------------------------------------
  // clear decode
  // ----------------------------------------------------------------
  logic [4:0] mot_r, mot_nxt, mot_evt, mot_clr;
  logic acq_r, acq_nxt, acq_evt, acq_clr;
  logic [2:0] q_r, q_nxt, q_evt, lvl_r, lvl_nxt;
  logic [5:0] cnt_r, cnt_nxt;
  logic [TW-1:0] tmr_r, tmr_nxt;
  acis_pkg::acis_tf_t tf_r;
  wire is_latch = MODE == acis_pkg::ACIS_M_LATCH;
  wire is_temp = MODE == acis_pkg::ACIS_M_TEMP;
  wire is_auto = MODE == acis_pkg::ACIS_M_AUTO;
  wire wr_stat = HOST.wr && hit(HOST, `ACIS_ADDR_ISTAT);
  wire wr_mstat = HOST.wr && hit(HOST, `ACIS_ADDR_MSTAT);
  wire glob_clr = !PER_BIT_CLEAR_SELECT && (wr_stat || wr_mstat);
  wire [7:0] bit_clr = (PER_BIT_CLEAR_SELECT && wr_stat) ? HOST.data : 8'h00;
  wire [7:0] sw_clr = glob_clr ? 8'hFF : bit_clr;
  wire q_clr = glob_clr || bit_clr[`ACIS_BIT_QCLR];
  wire tmo = is_temp && (tmr_r == TW'(TEMP_LATCH_CYCLES - 1));

  // ----------------------------------------------------------------
  // event detection
  // ----------------------------------------------------------------
  // tilted to flipped
  wire flip_tr = TF_EVAL && tf_r == acis_pkg::ACIS_TF_TILT && TF_STATE == acis_pkg::ACIS_TF_FLIP;
  wire tilt_tr = TF_EVAL && TF_STATE == acis_pkg::ACIS_TF_TILT
                 && (tf_r == acis_pkg::ACIS_TF_FLAT || tf_r == acis_pkg::ACIS_TF_FLIP);
  assign mot_evt = {TILT35_EVT, SHAKE_EVT, ANYM_EVT, flip_tr, tilt_tr} & INT_EN.mot;
  // sample flag in latched and auto modes
  assign acq_evt = Z_DONE && INT_EN.acq && (is_latch || is_auto);

  // ----------------------------------------------------------------
  // sample and motion flags
  // ----------------------------------------------------------------
  // hardware clears by mode
  assign mot_clr = sw_clr[4:0] | {5{tmo}} | (is_auto ? ~MOTION_COND : 5'h00);
  assign acq_clr = sw_clr[`ACIS_BIT_ACQ] || tmo || (is_auto && Z_ACCUM_START);
  assign mot_nxt = (mot_r & ~mot_clr) | mot_evt;
  assign acq_nxt = (acq_r && !acq_clr) || acq_evt;
  // temp latch timer restarts on each new event
  assign tmr_nxt = (!is_temp || (mot_evt != 5'h00) || acq_evt || tmo
                    || (mot_r == 5'h00 && !acq_r)) ? '0 : tmr_r + TW'(1);

  // ----------------------------------------------------------------
  // queue occupancy and flags
  // ----------------------------------------------------------------
  // writes only in wake with queue enabled
  wire q_push = SAMPLE_WR && WAKE && QUEUE_EN && cnt_r != 6'(QUEUE_DEPTH);
  wire q_pop = HOST.rd && hit(HOST, `ACIS_ADDR_QDATA) && cnt_r != 6'h00;
  assign cnt_nxt = cnt_r + 6'(q_push) - 6'(q_pop);
  assign lvl_nxt[`ACIS_QBIT_EMPTY] = cnt_nxt == 6'h00;
  assign lvl_nxt[`ACIS_QBIT_FULL] = cnt_nxt == 6'(QUEUE_DEPTH);
  assign lvl_nxt[`ACIS_QBIT_THR] = cnt_nxt >= QUEUE_THRESH;
  // queue flags only in latched mode
  assign q_evt = (lvl_nxt & ~lvl_r) & INT_EN.queue & {3{QUEUE_EN && is_latch}};
  assign q_nxt = (q_r & ~{3{q_clr}}) | q_evt;

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      mot_r <= 5'h00;
      acq_r <= 1'b0;
      q_r <= `ACIS_RST_QFLAGS;
      lvl_r <= `ACIS_RST_LEVEL;
      cnt_r <= 6'h00;
      tmr_r <= '0;
      tf_r <= acis_pkg::ACIS_TF_FLAT;
    end else begin
      mot_r <= mot_nxt;
      acq_r <= acq_nxt;
      q_r <= q_nxt;
      lvl_r <= lvl_nxt;
      cnt_r <= cnt_nxt;
      tmr_r <= tmr_nxt;
      if (TF_EVAL) begin
        tf_r <= TF_STATE;
      end
    end
  end

  // ----------------------------------------------------------------
  // registered outputs
  // ----------------------------------------------------------------
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      INT1_REQ <= 1'b0;
      INT2_REQ <= 1'b0;
    end else begin
      INT1_REQ <= (mot_nxt != 5'h00) || acq_nxt;
      INT2_REQ <= q_nxt != 3'h0;
    end
  end

  assign INT_STATUS = {acq_r, 2'h0, mot_r};
  assign QUEUE_STATUS = q_r;
  assign QUEUE_LEVEL = lvl_r;
  assign QUEUE_COUNT = cnt_r;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  wire no_evt = mot_evt == 5'h00 && !acq_evt;

  a_perbit_ignores_04: assert property (
    (PER_BIT_CLEAR_SELECT && wr_mstat && !wr_stat && is_latch && no_evt)
    |=> INT_STATUS == $past(INT_STATUS))
    else $error("per-bit write to 0x04 changed flags");
  a_global_clear_all: assert property (
    (glob_clr && no_evt && q_evt == 3'h0) |=> (INT_STATUS == 8'h00 && QUEUE_STATUS == 3'h0))
    else $error("global clear left flags set");
  a_bitmask_clear: assert property (
    (PER_BIT_CLEAR_SELECT && wr_stat && is_latch && no_evt)
    |=> INT_STATUS == ($past(INT_STATUS) & ~{$past(HOST.data[7]), 2'h0, $past(HOST.data[4:0])}))
    else $error("per-bit clear mismatch");
  a_queue_bit_clear: assert property (
    (PER_BIT_CLEAR_SELECT && wr_stat && HOST.data[`ACIS_BIT_QCLR] && q_evt == 3'h0)
    |=> QUEUE_STATUS == 3'h0)
    else $error("queue flags not cleared by bit 5");
  a_queue_latch_only: assert property (
    !is_latch |=> (QUEUE_STATUS & ~$past(QUEUE_STATUS)) == 3'h0)
    else $error("queue flag set outside latched mode");
  a_full_level: assert property (
    QUEUE_LEVEL[`ACIS_QBIT_FULL] == (QUEUE_COUNT == 6'(QUEUE_DEPTH)))
    else $error("full level wrong");
  a_empty_level: assert property (
    QUEUE_LEVEL[`ACIS_QBIT_EMPTY] == (QUEUE_COUNT == 6'h00))
    else $error("empty level wrong");
  a_write_gated: assert property (
    (!(WAKE && QUEUE_EN) && !HOST.rd) |=> $stable(QUEUE_COUNT))
    else $error("sample stored outside wake with queue enabled");
  a_read_pops: assert property (
    (q_pop && !q_push) |=> QUEUE_COUNT == $past(QUEUE_COUNT) - 6'h01)
    else $error("queue read did not remove a sample");
  a_flip_sets: assert property (
    (flip_tr && INT_EN.mot[`ACIS_BIT_FLIP]) |=> (INT_STATUS[`ACIS_BIT_FLIP] && INT1_REQ))
    else $error("flip event lost");
  a_acq_autoclr: assert property (
    (is_auto && Z_ACCUM_START && !acq_evt) |=> !INT_STATUS[`ACIS_BIT_ACQ])
    else $error("sample flag kept at accumulation start");
  a_temp_timeout: assert property (
    (tmo && no_evt) |=> (INT_STATUS == 8'h00))
    else $error("timeout did not clear flags");
  a_int1_follows: assert property (
    INT1_REQ == (INT_STATUS != 8'h00))
    else $error("sample and motion request out of step with flags");
  a_int2_follows: assert property (
    INT2_REQ == (QUEUE_STATUS != 3'h0))
    else $error("queue request out of step with queue flags");
  a_enable_gates: assert property (
    1'b1 |=> (INT_STATUS[4:0] & ~$past(INT_STATUS[4:0]) & ~$past(INT_EN.mot)) == 5'h00)
    else $error("motion flag set with its enable low");
  a_auto_cond_clr: assert property (
    (is_auto && mot_evt == 5'h00) |=> (INT_STATUS[4:0] & ~$past(MOTION_COND)) == 5'h00)
    else $error("motion flag kept after its condition ended");

  c_global_clear: cover property (glob_clr && INT_STATUS != 8'h00);
  c_bitmask_clear: cover property (PER_BIT_CLEAR_SELECT && wr_stat && INT_STATUS != 8'h00);
  c_queue_full: cover property (q_evt[`ACIS_QBIT_FULL]);
  c_temp_timeout: cover property (tmo && INT_STATUS != 8'h00);
  c_flip_set: cover property (flip_tr && INT_EN.mot[`ACIS_BIT_FLIP]);

endmodule : acis_irq

// ### acis_regs.svh
// register addresses, bit positions, reset values and timing for interrupt servicing
`ifndef ACIS_REGS_SVH
`define ACIS_REGS_SVH

// ----------------------------------------------------------------
// register addresses
// ----------------------------------------------------------------
`define ACIS_ADDR_MSTAT 8'h04
`define ACIS_ADDR_ISTAT 8'h14
`define ACIS_ADDR_QDATA 8'h0D

// ----------------------------------------------------------------
// interrupt status bit positions
// ----------------------------------------------------------------
`define ACIS_BIT_TILT 0
`define ACIS_BIT_FLIP 1
`define ACIS_BIT_ANYM 2
`define ACIS_BIT_SHAKE 3
`define ACIS_BIT_TILT35 4
`define ACIS_BIT_QCLR 5
`define ACIS_BIT_ACQ 7

// ----------------------------------------------------------------
// queue flag bit positions
// ----------------------------------------------------------------
`define ACIS_QBIT_EMPTY 0
`define ACIS_QBIT_FULL 1
`define ACIS_QBIT_THR 2

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define ACIS_RST_STATUS 8'h00
`define ACIS_RST_QFLAGS 3'h0
`define ACIS_RST_LEVEL 3'h1

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define ACIS_CLK_MHZ 40
`define ACIS_TEMP_LATCH_US 250
`define ACIS_TEMP_LATCH_CYC (`ACIS_TEMP_LATCH_US * `ACIS_CLK_MHZ)
`define ACIS_QUEUE_DEPTH 32

`endif

// ### acis_pkg.sv
// types for the interrupt servicing block
package acis_pkg;

  // ----------------------------------------------------------------
  // servicing modes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ACIS_M_RSV = 2'h0,
    ACIS_M_LATCH = 2'h1,
    ACIS_M_TEMP = 2'h2,
    ACIS_M_AUTO = 2'h3
  } acis_mode_t;

  // ----------------------------------------------------------------
  // orientation states, one-hot
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ACIS_TF_FLAT = 3'h1,
    ACIS_TF_TILT = 3'h2,
    ACIS_TF_FLIP = 3'h4
  } acis_tf_t;

  // ----------------------------------------------------------------
  // host register access
  // ----------------------------------------------------------------
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] data;
  } acis_host_t;

  // ----------------------------------------------------------------
  // interrupt enables
  // ----------------------------------------------------------------
  typedef struct packed {
    logic acq;
    logic [4:0] mot;
    logic [2:0] queue;
  } acis_en_t;

endpackage : acis_pkg

// ### acis_host_mdl.sv
// host-side register access model driving the block's register strobes
module acis_host_mdl (
  input wire logic CLK,
  input wire logic RST,
  input wire logic go_wr,
  input wire logic go_rd,
  input wire logic [7:0] addr,
  input wire logic [7:0] data,
  output acis_pkg::acis_host_t host
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] last_r;
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      last_r <= 16'h0000;
    end else if (go_wr || go_rd) begin
      last_r <= {addr, data};
    end
  end
  // one strobe per queue read
  // released address and data show the inverse of the last access
  assign host = (go_wr || go_rd) ? {go_wr, go_rd, addr, data} : {2'h0, ~last_r};
endmodule : acis_host_mdl

// ### tb_accel_interrupt_servicing.sv
// self-checking bench for the interrupt flag servicing block
module tb_accel_interrupt_servicing;
  timeunit 1ns;
  timeprecision 1ps;
  logic CLK = 1'b0;
  logic RST = 1'b1;
  logic go_wr = 1'b0;
  logic go_rd = 1'b0;
  logic [7:0] ha = 8'h00;
  logic [7:0] hd = 8'h00;
  logic [7:0] m;
  logic [5:0] pls = 6'h00;
  logic [4:0] cond = 5'h1F;
  logic pbc = 1'b0;
  logic wake = 1'b0;
  logic qen = 1'b0;
  logic swr = 1'b0;
  acis_pkg::acis_mode_t mode = acis_pkg::ACIS_M_LATCH;
  acis_pkg::acis_en_t en = 9'h1FF;
  acis_pkg::acis_tf_t tfs = acis_pkg::ACIS_TF_FLAT;
  acis_pkg::acis_host_t host;
  logic [7:0] ist;
  logic [2:0] qst;
  logic [2:0] qlv;
  logic [5:0] qcnt;
  logic i1;
  logic i2;
  int miscompares = 0;
  int checked = 0;
  always #12.5 CLK = ~CLK;
  acis_host_mdl host_u (.CLK(CLK), .RST(RST), .go_wr(go_wr), .go_rd(go_rd), .addr(ha),
    .data(hd), .host(host));
  acis_irq #(.TEMP_LATCH_CYCLES(8)) dut_u (.CLK(CLK), .RST(RST), .HOST(host), .INT_EN(en),
    .MODE(mode), .PER_BIT_CLEAR_SELECT(pbc), .Z_DONE(pls[3]), .Z_ACCUM_START(pls[4]),
    .TF_EVAL(pls[5]), .TF_STATE(tfs), .ANYM_EVT(pls[0]), .SHAKE_EVT(pls[1]),
    .TILT35_EVT(pls[2]), .MOTION_COND(cond), .WAKE(wake), .QUEUE_EN(qen), .SAMPLE_WR(swr),
    .QUEUE_THRESH(6'h10), .INT_STATUS(ist), .QUEUE_STATUS(qst), .QUEUE_LEVEL(qlv),
    .QUEUE_COUNT(qcnt), .INT1_REQ(i1), .INT2_REQ(i2));
  task print_verdict;
    $display("counts checked=%0d miscompares=%0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : print_verdict
  task chk8(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch t=%0t byte got=%h exp=%h", $time, got, exp);
    end
  endtask : chk8
  task chk3(input logic [2:0] got, input logic [2:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch t=%0t queue got=%h exp=%h", $time, got, exp);
    end
  endtask : chk3
  // flags left after a per-bit write: bits 0-4 and 7 clear, 5 and 6 read zero
  function automatic logic [7:0] exp_after_clr(input logic [7:0] s, input logic [7:0] d);
    exp_after_clr = s & ~{d[7], 2'h0, d[4:0]};
  endfunction : exp_after_clr
  // event pulses: 0 motion, 1 shake, 2 tilt35, 3 z done, 4 z start, 5 orientation
  task pulse(input logic [5:0] p);
    @(posedge CLK);
    pls <= p;
    @(posedge CLK);
    pls <= 6'h00;
    #1;
  endtask : pulse
  task tf(input acis_pkg::acis_tf_t s);
    @(posedge CLK);
    tfs <= s;
    pls <= 6'h20;
    @(posedge CLK);
    pls <= 6'h00;
    #1;
  endtask : tf
  task hw(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge CLK);
    go_wr <= w;
    go_rd <= !w;
    ha <= a;
    hd <= d;
    @(posedge CLK);
    go_wr <= 1'b0;
    go_rd <= 1'b0;
    #1;
  endtask : hw
  task push(input int n);
    @(posedge CLK);
    swr <= 1'b1;
    repeat (n) @(posedge CLK);
    swr <= 1'b0;
    #1;
  endtask : push
  task wait_clr;
    int i;
    for (i = 0; i < 20 && ist !== 8'h00; i++) begin
      @(posedge CLK);
      #1;
    end
    if (ist !== 8'h00) begin
      miscompares++;
      $display("mismatch t=%0t flags never cleared", $time);
      print_verdict();
    end
  endtask : wait_clr
  initial begin
    m = 8'($urandom(32'hC729));
    repeat (4) @(posedge CLK);
    RST <= 1'b0;
    #1;
    chk8(ist, 8'h00);
    chk3(qlv, 3'h1);
    tf(acis_pkg::ACIS_TF_TILT);
    chk8(ist, 8'h01);
    tf(acis_pkg::ACIS_TF_FLIP);
    chk8(ist, 8'h03);
    hw(1'b1, 8'h04, 8'($urandom));
    chk8(ist, 8'h00);
    tf(acis_pkg::ACIS_TF_TILT);
    tf(acis_pkg::ACIS_TF_FLAT);
    chk8(ist, 8'h01);
    hw(1'b1, 8'h05, 8'hFF);
    chk8(ist, 8'h01);
    en.mot[2] <= 1'b0;
    pulse(6'h01);
    chk8(ist, 8'h01);
    en.mot[2] <= 1'b1;
    pulse(6'h0F);
    chk8(ist, 8'h9D);
    tf(acis_pkg::ACIS_TF_TILT);
    tf(acis_pkg::ACIS_TF_FLIP);
    chk8(ist, 8'h9F);
    pbc <= 1'b1;
    hw(1'b1, 8'h04, 8'hFF);
    chk8(ist, 8'h9F);
    m = 8'($urandom);
    hw(1'b1, 8'h14, m);
    chk8(ist, exp_after_clr(8'h9F, m));
    hw(1'b1, 8'h14, 8'hFF);
    chk8({7'h00, i1}, 8'h00);
    qen <= 1'b1;
    push(5);
    chk8({2'h0, qcnt}, 8'h00);
    wake <= 1'b1;
    push(33);
    chk8({2'h0, qcnt}, 8'h20);
    chk3(qst, 3'h6);
    chk3(qlv, 3'h6);
    chk8({7'h00, i2}, 8'h01);
    hw(1'b1, 8'h14, 8'h20);
    chk3(qst, 3'h0);
    chk8({7'h00, i2}, 8'h00);
    hw(1'b0, 8'h0D, 8'h00);
    chk8({2'h0, qcnt}, 8'h1F);
    repeat (32) hw(1'b0, 8'h0D, 8'h00);
    chk8({2'h0, qcnt}, 8'h00);
    chk3(qst, 3'h1);
    pbc <= 1'b0;
    hw(1'b1, 8'h14, 8'($urandom));
    chk3(qst, 3'h0);
    mode <= acis_pkg::ACIS_M_AUTO;
    push(1);
    hw(1'b0, 8'h0D, 8'h00);
    chk3(qst, 3'h0);
    pulse(6'h08);
    chk8(ist, 8'h80);
    pulse(6'h10);
    chk8(ist, 8'h00);
    pulse(6'h01);
    cond <= 5'h1B;
    wait_clr();
    chk8(ist, 8'h00);
    cond <= 5'h1F;
    mode <= acis_pkg::ACIS_M_TEMP;
    pulse(6'h01);
    pulse(6'h00);
    chk8(ist, 8'h04);
    wait_clr();
    chk8(ist, 8'h00);
    print_verdict();
  end
endmodule : tb_accel_interrupt_servicing
